// ---- logic/flag_alu.sv ----
/*
   8-bit alu result and arithmetic flag computation.
   assumes flagsIn is the current flag register; purely combinational.
*/
`timescale 1ns/100ps
module flag_alu
   import indirect_flags_pkg::*;
(
   // operation and current flags
   input  wire alu_req_s   req,
   input  wire logic [7:0] flagsIn,
   // outputs
   output logic [7:0]      result,
   output logic [7:0]      flagsOut,
   output logic            affects
);

   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] addend;
   logic       carryIn;

   always_comb begin
      addend  = (req.op == OP_SUB) ? ~req.b : req.b;
      carryIn = (req.op == OP_SUB);
      sum     = {1'b0, req.a} + {1'b0, addend} + {8'h00, carryIn};
      nib     = {1'b0, req.a[3:0]} + {1'b0, addend[3:0]} + {4'h0, carryIn};
   end

   // result and flags per operation
   always_comb begin
      result   = 8'h00;
      flagsOut = flagsIn & FLAGS_MASK;
      affects  = 1'b1;
      case (req.op)
         OP_ADD, OP_SUB: begin
            result = sum[7:0];
            flagsOut[FLAG_C]  = sum[8];
            flagsOut[FLAG_DC] = nib[4];
            flagsOut[FLAG_OV] = (req.a[7] == addend[7]) && (sum[7] != req.a[7]);
         end
         OP_AND:  result = req.a & req.b;
         OP_IOR:  result = req.a | req.b;
         OP_XOR:  result = req.a ^ req.b;
         OP_RRC: begin
            result = {flagsIn[FLAG_C], req.a[7:1]};
            flagsOut[FLAG_C]  = req.a[0];
            flagsOut[FLAG_DC] = req.a[4];
         end
         OP_RLC: begin
            result = {req.a[6:0], flagsIn[FLAG_C]};
            flagsOut[FLAG_C]  = req.a[7];
            flagsOut[FLAG_DC] = req.a[3];
         end
         OP_CLR:    result = 8'h00;
         OP_BITCLR: begin
            result  = req.a & ~(8'h01 << req.b[2:0]);
            affects = 1'b0;
         end
         OP_BITSET: begin
            result  = req.a | (8'h01 << req.b[2:0]);
            affects = 1'b0;
         end
         OP_SWAP: begin
            result  = {req.a[3:0], req.a[7:4]};
            affects = 1'b0;
         end
         OP_MOVE_FF, OP_MOVE_WF: begin
            result  = req.a;
            affects = 1'b0;
         end
         default: begin
            affects = 1'b0;
         end
      endcase
      if (affects) begin
         flagsOut[FLAG_N] = result[7];
         flagsOut[FLAG_Z] = (result == 8'h00);
      end
   end

endmodule // flag_alu

// ---- logic/indirect_addr_flags.sv ----
/*
   indirect data address generator with three 12-bit pointers, five alias
   modes each, and the arithmetic flag register, with an apb register port.
   assumes the core issues one access and one alu op per cycle at most and
   that the data ram answers a read in the same cycle it is addressed.
*/
//
// Behaviour
// - plain alias: pointer address, pointer unchanged
// - post-decrement: use pointer, then minus one
// - post-increment: use pointer, then plus one
// - pre-increment: add one, then use it
// - indexed: pointer plus signed working register
// - pointer stepping never touches any flag
// - stepping spans all twelve pointer bits
// - reading an alias gives 00h, sets zero
// - writing an alias stores nothing, flags kept
// - writing pointer byte stores, skips stepping
// - flag-affecting op into flags: flags win
// - bit, swap and move ops keep flags
// - flag bits 7..5 read zero
// - negative follows result msb
// - overflow on signed sign-bit change
// - zero flag set on zero result
// - digit carry from bit 3, rotate bit
// - carry from msb, rotate end bit
// - subtract by two's complement, borrow inverted
// - three 12-bit pointers, high and low bytes
`timescale 1ns/100ps
module indirect_addr_flags
   import indirect_flags_pkg::*;
#(
   parameter int NUM_PTR = 3
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // apb register port
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // core indirect access request
   input  wire logic        accValid,
   input  wire acc_req_s    accReq,
   output logic             accDone,
   output logic [7:0]       accRdata,
   // data ram port
   output mem_req_s         memReq,
   input  wire logic [7:0]  memRdata,
   // core alu request
   input  wire logic        aluValid,
   input  wire alu_req_s    aluReq,
   output logic             aluDone,
   output logic [7:0]       aluResult,
   // flag register seen by the core
   output logic [7:0]       flags
);

   // refuse pointer counts the select field cannot reach
   if (NUM_PTR < 1 || NUM_PTR > MAX_PTRS) begin : g_check
      $error("NUM_PTR must be 1 to 4");
   end

   typedef struct packed {
      logic [NUM_PTR-1:0][11:0] ptr;
      logic [7:0]               flags;
      logic [7:0]               working_reg;
      mem_req_s                 mem;
      logic                     accDone;
      logic [7:0]               accRdata;
      logic                     aliasDone;
      logic                     aluDone;
      logic [7:0]               aluResult;
      logic [31:0]              prdata;
      logic                     pslverr;
      logic [11:0]              lastAddr;
      logic                     lastAlias;
      logic                     lastPtrByte;
   } state_s;

   state_s st_reg;
   state_s st_next;

   logic [11:0] selPtr;
   logic [11:0] effAddr;
   logic [11:0] ptrNext;
   logic [7:0]  aluOut;
   logic [7:0]  aluFlags;
   logic        aluAffects;
   logic        hitGroup;
   logic [1:0]  hitIdx;
   logic [2:0]  hitSlot;
   logic        hitAlias;
   logic        hitLow;
   logic        hitHigh;
   logic        apbSetup;
   logic        apbWrite;
   logic [3:0]  ptrWord;

   // pointer select past NUM_PTR uses PTR_RESET instead of a pointer
   assign selPtr = (32'(accReq.ptrSel) < NUM_PTR) ? st_reg.ptr[accReq.ptrSel] : PTR_RESET;

   ptr_unit u_ptr (
      .ptr     (selPtr),
      .mode    (accReq.mode),
      .working_reg    (st_reg.working_reg),
      .effAddr (effAddr),
      .ptrNext (ptrNext)
   );

   flag_alu u_alu (
      .req      (aluReq),
      .flagsIn  (st_reg.flags),
      .result   (aluOut),
      .flagsOut (aluFlags),
      .affects  (aluAffects)
   );

   // decode the target: alias slot or pointer byte of a present pointer, none when NUM_PTR is 4
   always_comb begin
      hitGroup = inGroup(effAddr, NUM_PTR);
      hitIdx   = 2'((effAddr - ALIAS_BASE) >> 3);
      hitSlot  = effAddr[2:0];
      hitAlias = hitGroup && (hitSlot < SLOT_ALIASES);
      hitLow   = hitGroup && (hitSlot == SLOT_LOW);
      hitHigh  = hitGroup && (hitSlot == SLOT_HIGH);
   end

   // apb phases; zero wait states
   assign apbSetup = psel && !penable;
   assign apbWrite = psel && penable && pwrite;
   // word index: bit 0 picks the high byte at 8n+4, the rest the pointer
   assign ptrWord  = paddr[5:2];

   // next state
   always_comb begin
      st_next           = st_reg;
      st_next.mem.valid = 1'b0;
      st_next.accDone   = 1'b0;
      st_next.aliasDone = 1'b0;
      st_next.aluDone   = 1'b0;

      // ram read finishes one cycle after the request edge
      if (st_reg.mem.valid && !st_reg.mem.write) begin
         st_next.accRdata = memRdata;
         st_next.accDone  = 1'b1;
      end else if (st_reg.mem.valid || st_reg.aliasDone) begin
         st_next.accDone = 1'b1;
      end

      // apb write; flags and pointers share with the core, core wins below
      if (apbWrite) begin
         if (paddr <= OFS_PTR_LAST && paddr[1:0] == 2'b00 && 32'(ptrWord >> 1) < NUM_PTR) begin
            if (ptrWord[0]) begin
               st_next.ptr[ptrWord >> 1][11:8] = pwdata[3:0];
            end else begin
               st_next.ptr[ptrWord >> 1][7:0] = pwdata[7:0];
            end
         end else if (paddr == OFS_FLAGS) begin
            st_next.flags = pwdata[7:0] & FLAGS_MASK;
         end else if (paddr == OFS_WORKING_REG) begin
            st_next.working_reg = pwdata[7:0];
         end
      end

      // core alu operation
      if (aluValid) begin
         st_next.aluDone   = 1'b1;
         st_next.aluResult = aluOut;
         if (aluAffects) begin
            st_next.flags = aluFlags;
         end else if (aluReq.destFlags) begin
            st_next.flags = aluOut & FLAGS_MASK;
         end
      end

      // core indirect access; pointer write-back on the request edge
      if (accValid) begin
         st_next.lastAddr    = effAddr;
         st_next.lastAlias   = hitAlias;
         st_next.lastPtrByte = accReq.write && (hitLow || hitHigh);
         if (hitAlias) begin
            st_next.aliasDone = 1'b1;
            if (!accReq.write) begin
               st_next.accRdata      = ALIAS_READ;
               st_next.flags[FLAG_Z] = 1'b1;
            end
         end else if (accReq.write && (hitLow || hitHigh)) begin
            st_next.aliasDone = 1'b1;
            if (hitHigh) begin
               st_next.ptr[hitIdx][11:8] = accReq.wdata[3:0];
            end else begin
               st_next.ptr[hitIdx][7:0] = accReq.wdata;
            end
         end else begin
            st_next.mem.valid = 1'b1;
            st_next.mem.write = accReq.write;
            st_next.mem.addr  = effAddr;
            st_next.mem.wdata = accReq.wdata;
            if (32'(accReq.ptrSel) < NUM_PTR) begin
               st_next.ptr[accReq.ptrSel] = ptrNext;
            end
         end
         // reading pointer bytes indirectly goes through the ram path;
         // the ram is expected to mirror them, a known limitation
      end

      // apb read data captured in the setup cycle
      if (apbSetup) begin
         st_next.prdata  = 32'h0000_0000;
         st_next.pslverr = 1'b0;
         if (paddr <= OFS_PTR_LAST && paddr[1:0] == 2'b00 && 32'(ptrWord >> 1) < NUM_PTR) begin
            if (ptrWord[0]) begin
               st_next.prdata[3:0] = st_reg.ptr[ptrWord >> 1][11:8];
            end else begin
               st_next.prdata[7:0] = st_reg.ptr[ptrWord >> 1][7:0];
            end
         end else if (paddr == OFS_FLAGS) begin
            st_next.prdata[7:0] = st_reg.flags & FLAGS_MASK;
         end else if (paddr == OFS_WORKING_REG) begin
            st_next.prdata[7:0] = st_reg.working_reg;
         end else if (paddr == OFS_LAST) begin
            st_next.prdata[13:0] = {st_reg.lastPtrByte, st_reg.lastAlias, st_reg.lastAddr};
         end else begin
            st_next.pslverr = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '0;
         st_reg.flags <= FLAGS_RESET;
         st_reg.working_reg  <= WORKING_REG_RESET;
         for (int i = 0; i < NUM_PTR; i++) begin
            st_reg.ptr[i] <= PTR_RESET;
         end
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs
   assign pready    = psel && penable;
   assign prdata    = st_reg.prdata;
   assign pslverr   = st_reg.pslverr && psel && penable;
   assign accDone   = st_reg.accDone;
   assign accRdata  = st_reg.accRdata;
   assign memReq    = st_reg.mem;
   assign aluDone   = st_reg.aluDone;
   assign aluResult = st_reg.aluResult;
   assign flags     = st_reg.flags & FLAGS_MASK;

endmodule // indirect_addr_flags

// ---- logic/indirect_flags_pkg.sv ----
/*
   shared constants, types and decode helpers for the indirect address
   generator and the arithmetic flag register.
   assumes a 12-bit data space with an 8-bit data path.
*/
package indirect_flags_pkg;

   // data space and pointer geometry
   localparam int          PTR_W        = 12;
   localparam int          DATA_W       = 8;
   localparam int          MAX_PTRS     = 4;
   localparam logic [11:0] ALIAS_BASE   = 12'hFE0;
   localparam logic [11:0] ALIAS_STRIDE = 12'h008;
   localparam logic [2:0]  SLOT_LOW     = 3'h5;
   localparam logic [2:0]  SLOT_HIGH    = 3'h6;
   localparam logic [2:0]  SLOT_ALIASES = 3'h5;

   // flag bit positions, values after reset and the alias read value
   localparam int          FLAG_C      = 0;
   localparam int          FLAG_DC     = 1;
   localparam int          FLAG_Z      = 2;
   localparam int          FLAG_OV     = 3;
   localparam int          FLAG_N      = 4;
   localparam logic [7:0]  FLAGS_MASK  = 8'h1F;
   localparam logic [7:0]  FLAGS_RESET = 8'h00;
   localparam logic [11:0] PTR_RESET   = 12'h000;
   localparam logic [7:0]  WORKING_REG_RESET  = 8'h00;
   localparam logic [7:0]  ALIAS_READ  = 8'h00;

   // apb byte offsets
   localparam logic [7:0]  OFS_PTR0_LOW = 8'h00;
   localparam logic [7:0]  OFS_PTR_LAST = 8'h1C;
   localparam logic [7:0]  OFS_FLAGS    = 8'h20;
   localparam logic [7:0]  OFS_WORKING_REG     = 8'h24;
   localparam logic [7:0]  OFS_LAST     = 8'h28;

   typedef enum logic [2:0] {
      MODE_PLAIN, MODE_POST_DEC, MODE_POST_INC, MODE_PRE_INC, MODE_INDEXED
   } ptr_mode_e;

   typedef enum logic [3:0] {
      OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_RRC, OP_RLC, OP_CLR,
      OP_BITCLR, OP_BITSET, OP_SWAP, OP_MOVE_FF, OP_MOVE_WF
   } alu_op_e;

   typedef struct packed {
      logic [1:0]  ptrSel;
      ptr_mode_e   mode;
      logic        write;
      logic [7:0]  wdata;
   } acc_req_s;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } mem_req_s;

   typedef struct packed {
      alu_op_e     op;
      logic [7:0]  a;
      logic [7:0]  b;
      logic        destFlags;
   } alu_req_s;

   // address of one alias or pointer byte slot of pointer idx
   function automatic logic [11:0] slotAddr(input logic [1:0] idx, input logic [2:0] slot);
      slotAddr = ALIAS_BASE + ALIAS_STRIDE * {10'h000, idx} + {9'h000, slot};
   endfunction

   // true when addr falls in the slot group of a present pointer for numPtr 1 to 3; at 4 the 12-bit bound wraps to 000h, never true
   function automatic logic inGroup(input logic [11:0] addr, input int numPtr);
      inGroup = (addr >= ALIAS_BASE) &&
                (addr < ALIAS_BASE + ALIAS_STRIDE * 12'(numPtr));
   endfunction

endpackage

// ---- logic/ptr_unit.sv ----
/*
   effective address and next pointer value for one alias access.
   assumes the caller writes ptrNext back in the same cycle it uses effAddr.
*/
`timescale 1ns/100ps
module ptr_unit
   import indirect_flags_pkg::*;
(
   // selected pointer and offset source
   input  wire logic [11:0] ptr,
   input  wire ptr_mode_e   mode,
   input  wire logic [7:0]  working_reg,
   // results
   output logic [11:0]      effAddr,
   output logic [11:0]      ptrNext
);

   logic [11:0] incr;
   logic [11:0] decr;

   // full 12-bit arithmetic, wraps modulo 4096
   // carry into high byte
   assign incr = ptr + 12'h001;
   assign decr = ptr - 12'h001;

   // address select and write-back value per alias
   always_comb begin
      effAddr = ptr;
      ptrNext = ptr;
      case (mode)
         MODE_PLAIN: begin
            effAddr = ptr;
         end
         MODE_POST_DEC: begin
            ptrNext = decr;
         end
         MODE_POST_INC: begin
            ptrNext = incr;
         end
         MODE_PRE_INC: begin
            effAddr = incr;
            ptrNext = incr;
         end
         MODE_INDEXED: begin
            effAddr = ptr + {{4{working_reg[7]}}, working_reg};
         end
         default: begin
            effAddr = ptr;
         end
      endcase
   end

endmodule // ptr_unit

// ---- tb/data_ram_model.sv ----
/* data ram on the block's memory port.
   writes land at the edge; reads answer in the addressed cycle only. */
`timescale 1ns/100ps
module data_ram_model
   import indirect_flags_pkg::*;
(
   // clock and ram port
   input  wire logic     clk,
   input  wire mem_req_s memReq,
   output logic [7:0]    memRdata
);
   logic [7:0] mem [4096];
   logic [7:0] junk = 8'h5A;
   // known contents so unwritten reads are predictable
   initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'hA5;
   // idle data churns so a late sample never looks right
   always @(posedge clk) begin
      if (memReq.valid && memReq.write) mem[memReq.addr] <= memReq.wdata;
      junk <= ~junk;
   end
   assign memRdata = (memReq.valid && !memReq.write) ? mem[memReq.addr] : junk;
endmodule // data_ram_model

// ---- tb/indirect_addr_flags_chk.sv ----
/* timing and flag relations of the indirect address and flag block.
   sees only the top ports; bound to every instance at the foot. */
`timescale 1ns/100ps
module indirect_addr_flags_chk
   import indirect_flags_pkg::*;
#(parameter int NUM_PTR = 3)
(
   // clock, reset and apb strobes
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   // core side
   input wire logic       accValid,
   input wire logic       accDone,
   input wire logic [7:0] accRdata,
   input wire mem_req_s   memReq,
   input wire logic [7:0] memRdata,
   input wire logic       aluValid,
   input wire alu_req_s   aluReq,
   input wire logic [7:0] aluResult,
   input wire logic [7:0] flags
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic accPrev;
   // access pulse one cycle back, since the ram strobe follows the access by one cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) accPrev <= 1'h0;
      else accPrev <= accValid;
   end
   acc_latency_a: assert property (accValid |-> ##2 accDone)
      else $error("access not done two cycles after take");
   mem_issue_a: assert property (memReq.valid |-> accPrev)
      else $error("ram strobe without an access");
   read_return_a: assert property (memReq.valid && !memReq.write |=>
      accDone && accRdata == $past(memRdata)) else $error("read data lost");
   flag_upper_a: assert property (flags[7:5] == 3'h0)
      else $error("unused flag bits set");
   add_carry_a: assert property (aluValid && aluReq.op == OP_ADD |=>
      {flags[FLAG_C], aluResult} == {1'h0, $past(aluReq.a)} + {1'h0, $past(aluReq.b)})
      else $error("add sum or carry wrong");
   sub_borrow_a: assert property (aluValid && aluReq.op == OP_SUB |=>
      {flags[FLAG_C], aluResult} ==
      {1'h0, $past(aluReq.a)} + {1'h0, ~$past(aluReq.b)} + 9'h001)
      else $error("subtract or borrow wrong");
   clr_dest_a: assert property (aluValid && aluReq.op == OP_CLR |=>
      flags == (($past(flags) & 8'h0B) | 8'h04)) else $error("clear flags wrong");
   neg_zero_a: assert property (aluValid && !accValid && !accPrev &&
      aluReq.op inside {OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR} |=>
      flags[FLAG_N] == aluResult[7] && flags[FLAG_Z] == (aluResult == 8'h00))
      else $error("negative or zero flag wrong");
   rot_carry_a: assert property (aluValid && aluReq.op == OP_RRC |=>
      flags[FLAG_C] == $past(aluReq.a[0]) && flags[FLAG_DC] == $past(aluReq.a[4]))
      else $error("rotate carry wrong");
   keep_flags_a: assert property (aluValid && !aluReq.destFlags && !accValid
      && !accPrev && !(psel && penable && pwrite) && aluReq.op inside
      {OP_BITCLR, OP_BITSET, OP_SWAP, OP_MOVE_FF, OP_MOVE_WF} |=> $stable(flags))
      else $error("flag-neutral op moved flags");
endmodule // indirect_addr_flags_chk

bind indirect_addr_flags indirect_addr_flags_chk #(.NUM_PTR(NUM_PTR)) u_chk (.clk, .resetn,
   .psel, .penable, .pwrite, .accValid, .accDone, .accRdata, .memReq, .memRdata,
   .aluValid, .aluReq, .aluResult, .flags);

// ---- tb/indirect_addr_flags_tb.sv ----
/* self-checking bench for the indirect address and flag block.
   drives apb, core access and alu ports; a ram model answers. */
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module indirect_addr_flags_tb
   import indirect_flags_pkg::*;
();
   logic        clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic        accValid = 1'h0, aluValid = 1'h0, pready, pslverr, accDone, aluDone, err;
   logic [7:0]  paddr = 8'h00, accRdata, memRdata, aluResult, flags;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   acc_req_s    accReq = '0;
   alu_req_s    aluReq = '0;
   mem_req_s    memReq;
   logic        sawMem;
   logic [11:0] memAddr, p;
   int          bad_count = 0, check_count = 0;
   always #12.5 clk = ~clk;
   indirect_addr_flags #(.NUM_PTR(3)) u_dut (.clk, .resetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .accValid, .accReq, .accDone,
      .accRdata, .memReq, .memRdata, .aluValid, .aluReq, .aluDone, .aluResult, .flags);
   data_ram_model u_ram (.clk, .memReq, .memRdata);
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic timeout();
      bad_count++;
      final_report();
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(logic w, logic [7:0] a, logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n >= 20) timeout();
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // pointer bytes: low at 8n, high nibble at 8n+4
   task automatic ptr_wr(logic [1:0] s, logic [11:0] v);
      apb(1'h1, {3'h0, s, 3'h0}, v[7:0]);
      apb(1'h1, {3'h0, s, 3'h4}, {4'h0, v[11:8]});
   endtask
   task automatic ptr_rd(logic [1:0] s);
      apb(1'h0, {3'h0, s, 3'h0}, 8'h00);
      p[7:0] = rd[7:0];
      apb(1'h0, {3'h0, s, 3'h4}, 8'h00);
      p[11:8] = rd[3:0];
   endtask
   // one core access; notes whether and where the ram was addressed
   task automatic acc(logic [1:0] s, ptr_mode_e m, logic w, logic [7:0] d);
      int n;
      n = 0;
      sawMem = 1'h0;
      memAddr = 'x;
      @(posedge clk);
      accValid <= 1'h1;
      accReq <= '{s, m, w, d};
      @(posedge clk);
      accValid <= 1'h0;
      do begin
         #1;
         if (memReq.valid === 1'h1) begin
            sawMem = 1'h1;
            memAddr = memReq.addr;
         end
         n++;
         if (accDone !== 1'h1) @(posedge clk);
      end while (accDone !== 1'h1 && n < 10);
      if (n >= 10) timeout();
   endtask
   task automatic step(ptr_mode_e m, logic [11:0] ea, logic [11:0] ep);
      acc(2'h0, m, 1'h0, 8'h00);
      `CHK(memAddr, ea)
      `CHK(flags, 8'h00)
      ptr_rd(2'h0);
      `CHK(p, ep)
   endtask
   // flags preset over apb, one alu op, flags judged after it
   task automatic alu(alu_op_e o, logic [7:0] a, b, logic d, logic [7:0] fi, fo);
      int n;
      n = 0;
      apb(1'h1, OFS_FLAGS, fi);
      @(posedge clk);
      aluValid <= 1'h1;
      aluReq <= '{o, a, b, d};
      @(posedge clk);
      aluValid <= 1'h0;
      #1;
      while (aluDone !== 1'h1 && n < 10) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 10) timeout();
      `CHK(flags, fo)
   endtask
   task automatic t_regs();
      apb(1'h0, OFS_FLAGS, 8'h00);
      `CHK(rd, {24'h0, FLAGS_RESET})
      ptr_rd(2'h2);
      `CHK(p, PTR_RESET)
      apb(1'h1, OFS_FLAGS, 8'hFF);
      apb(1'h0, OFS_FLAGS, 8'h00);
      `CHK(rd, 32'h0000001F)
      apb(1'h1, 8'h04, 8'hFF);
      apb(1'h0, 8'h04, 8'h00);
      `CHK(rd, 32'h0000000F)
      apb(1'h1, 8'h2C, 8'h55);
      `CHK(err, 1'h1)
      apb(1'h1, OFS_FLAGS, 8'h00);
   endtask
   task automatic t_modes();
      ptr_wr(2'h0, 12'h0FF);
      apb(1'h1, OFS_WORKING_REG, 8'h80);
      step(MODE_POST_INC, 12'h0FF, 12'h100);
      step(MODE_POST_DEC, 12'h100, 12'h0FF);
      step(MODE_PRE_INC, 12'h100, 12'h100);
      step(MODE_PLAIN, 12'h100, 12'h100);
      step(MODE_INDEXED, 12'h080, 12'h100);
      ptr_wr(2'h0, 12'hFFF);
      step(MODE_POST_INC, 12'hFFF, 12'h000);
      step(MODE_INDEXED, 12'hF80, 12'h000);
      step(MODE_POST_DEC, 12'h000, 12'hFFF);
      apb(1'h0, OFS_WORKING_REG, 8'h00);
      `CHK(rd[7:0], 8'h80)
   endtask
   task automatic t_data();
      ptr_wr(2'h1, 12'h200);
      acc(2'h1, MODE_POST_INC, 1'h1, 8'h3C);
      acc(2'h1, MODE_POST_DEC, 1'h0, 8'h00);
      `CHK(memAddr, 12'h201)
      `CHK(accRdata, 8'hA4)
      acc(2'h1, MODE_PLAIN, 1'h0, 8'h00);
      `CHK(accRdata, 8'h3C)
      // absent pointer select reads through a zero pointer
      acc(2'h3, MODE_POST_INC, 1'h0, 8'h00);
      `CHK({memAddr, accRdata}, {PTR_RESET, 8'hA5})
   endtask
   task automatic t_alias();
      ptr_wr(2'h2, ALIAS_BASE + 12'h002);
      apb(1'h1, OFS_FLAGS, 8'h11);
      acc(2'h2, MODE_PLAIN, 1'h0, 8'h00);
      `CHK({sawMem, accRdata, flags}, {1'h0, 8'h00, 8'h15})
      apb(1'h1, OFS_FLAGS, 8'h00);
      acc(2'h2, MODE_PLAIN, 1'h1, 8'h77);
      ptr_rd(2'h0);
      `CHK({sawMem, flags, p}, {1'h0, 8'h00, 12'hFFF})
      ptr_wr(2'h2, ALIAS_BASE + {9'h0, SLOT_LOW});
      acc(2'h2, MODE_POST_INC, 1'h1, 8'h34);
      ptr_rd(2'h0);
      `CHK({sawMem, p}, {1'h0, 12'hF34})
      ptr_rd(2'h2);
      `CHK(p, ALIAS_BASE + {9'h0, SLOT_LOW})
      // last-access status: pointer-byte write, not alias, address fe5
      apb(1'h0, OFS_LAST, 8'h00);
      `CHK(rd, 32'h00002FE5)
   endtask
   task automatic t_alu();
      alu(OP_ADD, 8'h7F, 8'h01, 1'h0, 8'h00, 8'h1A);
      `CHK(aluResult, 8'h80)
      alu(OP_ADD, 8'hFF, 8'h01, 1'h0, 8'h00, 8'h07);
      alu(OP_SUB, 8'h00, 8'h01, 1'h0, 8'h00, 8'h10);
      `CHK(aluResult, 8'hFF)
      alu(OP_SUB, 8'h05, 8'h03, 1'h0, 8'h00, 8'h03);
      alu(OP_SUB, 8'h80, 8'h01, 1'h0, 8'h00, 8'h09);
      alu(OP_AND, 8'hF0, 8'h0F, 1'h0, 8'h00, 8'h04);
      alu(OP_IOR, 8'h80, 8'h01, 1'h0, 8'h00, 8'h10);
      alu(OP_XOR, 8'h55, 8'h55, 1'h0, 8'h00, 8'h04);
      alu(OP_RRC, 8'h11, 8'h00, 1'h0, 8'h00, 8'h03);
      `CHK(aluResult, 8'h08)
      alu(OP_RLC, 8'h88, 8'h00, 1'h0, 8'h01, 8'h03);
      `CHK(aluResult, 8'h11)
      alu(OP_CLR, 8'h00, 8'h00, 1'h1, 8'h1B, 8'h0F);
      alu(OP_ADD, 8'h01, 8'h01, 1'h1, 8'h00, 8'h00);
      for (int i = OP_BITCLR; i <= OP_MOVE_WF; i++) begin
         alu(alu_op_e'(i), 8'hA5, 8'h00, 1'h0, 8'h1B, 8'h1B);
      end
   endtask
   // reset, then every scenario in turn
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'h1;
      t_regs();
      t_modes();
      t_data();
      t_alias();
      t_alu();
      final_report();
   end
endmodule // indirect_addr_flags_tb
